/* pkg/stim_consts.svh */
// Register offsets, field positions, reset values and counts for the timer interrupt block.
// Assumes inclusion by bare name from package and design files.
`ifndef STIM_CONSTS_SVH
`define STIM_CONSTS_SVH

`define STIM_ADDR_W 8
`define STIM_OFF_RTMODE 8'h0c
`define STIM_OFF_STATUS 8'h10
`define STIM_OFF_IEN 8'h14
`define STIM_OFF_IDIS 8'h18
`define STIM_OFF_IMASK 8'h1c
`define STIM_OFF_ALARM 8'h20
`define STIM_OFF_CRT 8'h24
`define STIM_BIT_PIT 0
`define STIM_BIT_DOG 1
`define STIM_BIT_RTINC 2
`define STIM_BIT_ALARM 3
`define STIM_NEV 4
`define STIM_RT_W 20
`define STIM_PRES_W 16
`define STIM_RTMODE_RESET 16'h8000
`define STIM_ALARM_RESET 20'h00000
`define STIM_SLOW_HZ 32768
`define STIM_SYS_HZ 250000000
`define STIM_SLOW_DIV (`STIM_SYS_HZ / `STIM_SLOW_HZ)

`endif

/* pkg/stim_pkg.sv */
// Types shared by the timer interrupt block.
// Assumes the constants header is on the include path.
`include "stim_consts.svh"
package stim_pkg;
  typedef logic [`STIM_NEV-1:0] stim_ev_t;
  typedef logic [`STIM_RT_W-1:0] stim_rt_t;
  typedef logic [`STIM_PRES_W-1:0] stim_pres_t;
endpackage : stim_pkg

/* pkg/stim_rt_if.sv */
// Carries the slow tick, prescale, and counter between timer modules.
// Assumes a single clock domain.
interface stim_rt_if;
  import stim_pkg::*;
  logic slow_tick;
  stim_pres_t rt_prescale_value;
  stim_rt_t rt_counter_value;
  logic rt_inc;
  modport ctr (input slow_tick, input rt_prescale_value, output rt_counter_value,
    output rt_inc);
  modport top (output slow_tick, output rt_prescale_value, input rt_counter_value,
    input rt_inc);
endinterface : stim_rt_if

/* logic/stim_slow_div.sv */
// Divides the system clock into a one-cycle slow clock enable.
// Assumes sys_clk at 250 MHz.
`include "stim_consts.svh"
module stim_slow_div (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Enable out
  output logic tick
);
  import stim_pkg::*;
  localparam int unsigned DIV = `STIM_SLOW_DIV;
  logic [15:0] cnt_q;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end
    else if (cnt_q == 16'(DIV - 1))
    begin
      cnt_q <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule : stim_slow_div

/* logic/stim_rt_counter.sv */
// Real-time counter with prescaler on the slow clock enable.
// Assumes prescale zero means 65536 slow periods.
`include "stim_consts.svh"
module stim_rt_counter (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Timer link
  stim_rt_if.ctr rt
);
  import stim_pkg::*;
  stim_pres_t pre_q;
  logic pre_end;

  // A prescale of zero wraps the full 16-bit count, giving 65536 periods.
  // The end test is a bound, not an equality. A prescale that is lowered below the running
  // count then ends the period at once, and the count does not wrap through 65536 periods.
  assign pre_end = (pre_q >= (rt.rt_prescale_value - 16'h0001));

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pre_q <= 16'h0000;
      rt.rt_counter_value <= 20'h00000;
      rt.rt_inc <= 1'b0;
    end
    else
    begin
      rt.rt_inc <= 1'b0;
      if (rt.slow_tick)
      begin
        if (pre_end)
        begin
          pre_q <= 16'h0000;
          rt.rt_counter_value <= rt.rt_counter_value + 20'h00001;
          rt.rt_inc <= 1'b1;
        end
        else
          pre_q <= pre_q + 16'h0001;
      end
    end
  end
endmodule : stim_rt_counter

/* logic/stim_top.sv */
// Interrupt mask, status, real-time counter and alarm of the system timer.
// Assumes the period and watchdog events arrive as one-cycle pulses on sys_clk.
//
// The address-and-strobe port is this design's own decision.
`include "stim_consts.svh"

// Notes on behaviour
// - Enable write of one sets mask bit.
// - Disable write of one clears mask bit.
// - Mask read shows one bit per source.
// - Bits: period 0, dog 1, increment 2, alarm 3.
// - Alarm flag set when counter equals value.
// - Alarm value zero waits a full wrap.
// - Current register reads the counter.
// - Status flags set on event, read clears.
// - Counter steps every prescale slow periods.
module stim_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port
  input wire logic [`STIM_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Events from the sibling timers
  input wire logic period_tick_ev,
  input wire logic dog_overflow_ev,
  // Interrupt, status flags and counter
  output logic irq,
  output stim_pkg::stim_ev_t status_flags,
  output stim_pkg::stim_rt_t rt_counter_value
);
  import stim_pkg::*;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  stim_ev_t mask_q;
  stim_ev_t status_q;
  stim_ev_t ev_d;
  stim_rt_t alarm_compare_value;
  stim_pres_t rt_prescale_value;
  stim_rt_if rt_link ();
  logic alarm_hit;
  logic rt_inc_q;

  // ------------------------------------------------------------
  // Timebase
  // ------------------------------------------------------------
  stim_slow_div u_div (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .tick(rt_link.slow_tick)
  );

  stim_rt_counter u_ctr (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .rt(rt_link.ctr)
  );

  assign rt_link.rt_prescale_value = rt_prescale_value;
  assign rt_counter_value = rt_link.rt_counter_value;

  // Compare only on the cycle after an increment, so a value that was just
  // written and already equals the counter waits for the next full wrap.
  // A value of zero therefore matches after 2^20 increments.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rt_inc_q <= 1'b0;
    else
      rt_inc_q <= rt_link.rt_inc;
  end
  assign alarm_hit = rt_inc_q && (rt_link.rt_counter_value == alarm_compare_value);

  // ------------------------------------------------------------
  // Mask register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      mask_q <= 4'h0;
    else if (reg_wr && reg_addr == `STIM_OFF_IEN)
      mask_q <= mask_q | reg_wdata[`STIM_NEV-1:0];
    else if (reg_wr && reg_addr == `STIM_OFF_IDIS)
      mask_q <= mask_q & ~reg_wdata[`STIM_NEV-1:0];
  end

  // ------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------
  always_comb
  begin
    ev_d = 4'h0;
    ev_d[`STIM_BIT_PIT] = period_tick_ev;
    ev_d[`STIM_BIT_DOG] = dog_overflow_ev;
    ev_d[`STIM_BIT_RTINC] = rt_inc_q;
    ev_d[`STIM_BIT_ALARM] = alarm_hit;
  end

  // A new event in the reading cycle survives the clear.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      status_q <= 4'h0;
    else if (reg_rd && reg_addr == `STIM_OFF_STATUS)
      status_q <= ev_d;
    else
      status_q <= status_q | ev_d;
  end
  assign status_flags = status_q;

  assign irq = |(status_q & mask_q);

  // ------------------------------------------------------------
  // Writable settings
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      alarm_compare_value <= `STIM_ALARM_RESET;
      rt_prescale_value <= `STIM_RTMODE_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `STIM_OFF_ALARM)
        alarm_compare_value <= reg_wdata[`STIM_RT_W-1:0];
      if (reg_addr == `STIM_OFF_RTMODE)
        rt_prescale_value <= reg_wdata[`STIM_PRES_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `STIM_OFF_STATUS: reg_rdata <= {28'h0000000, status_q};
        `STIM_OFF_IMASK: reg_rdata <= {28'h0000000, mask_q};
        `STIM_OFF_ALARM: reg_rdata <= {12'h000, alarm_compare_value};
        `STIM_OFF_CRT: reg_rdata <= {12'h000, rt_link.rt_counter_value};
        `STIM_OFF_RTMODE: reg_rdata <= {16'h0000, rt_prescale_value};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  en_sets_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_wr && reg_addr == `STIM_OFF_IEN) |=> ((mask_q & $past(reg_wdata[3:0])) ==
    $past(reg_wdata[3:0])))
    else $error("enable write did not set mask");
  dis_clears_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_wr && reg_addr == `STIM_OFF_IDIS) |=> ((mask_q & $past(reg_wdata[3:0])) == 4'h0))
    else $error("disable write did not clear mask");
  mask_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_rd && reg_addr == `STIM_OFF_IMASK && !reg_wr) |=> (reg_rdata == {28'h0, $past(mask_q)}))
    else $error("mask read mismatch");
  mask_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(reg_wr && (reg_addr == `STIM_OFF_IEN || reg_addr == `STIM_OFF_IDIS)) |=> $stable(mask_q))
    else $error("mask changed without command");
  alarm_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    alarm_hit |=> status_q[`STIM_BIT_ALARM])
    else $error("alarm flag not raised");
  alarm_cause_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(status_q[`STIM_BIT_ALARM]) |-> $past(rt_inc_q))
    else $error("alarm without increment");
  crt_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_rd && reg_addr == `STIM_OFF_CRT) |=> (reg_rdata[19:0] == $past(rt_counter_value)))
    else $error("counter read mismatch");
  status_clr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_rd && reg_addr == `STIM_OFF_STATUS && ev_d == 4'h0) |=> (status_q == 4'h0))
    else $error("status not cleared by read");
  rt_step_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rt_link.rt_inc |-> (rt_counter_value == $past(rt_counter_value) + 20'h1))
    else $error("counter step wrong");
  irq_level_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    irq == ((status_q & mask_q) != 4'h0))
    else $error("interrupt level wrong");
  irq_seen_c: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(irq));
  alarm_seen_c: cover property (@(posedge sys_clk) disable iff (!nrst) alarm_hit);
  read_clear_c: cover property (@(posedge sys_clk) disable iff (!nrst)
    reg_rd && reg_addr == `STIM_OFF_STATUS && status_q != 4'h0);
  mask_enable_c: cover property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && reg_addr == `STIM_OFF_IEN && reg_wdata[3:0] != 4'h0);
  rt_step_c: cover property (@(posedge sys_clk) disable iff (!nrst) rt_link.rt_inc);

  // Read data stand for one cycle only, so a bus idle cycle must show zero.
  rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !reg_rd |=> (reg_rdata == 32'h0000_0000))
    else $error("read data not zero after idle cycle");
  // A set flag must stay set until a status read.
  status_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(reg_rd && reg_addr == `STIM_OFF_STATUS) |=> ((status_q & $past(status_q)) ==
    $past(status_q)))
    else $error("status flag lost without read");
endmodule : stim_top

/* bench/stim_top_tb.sv */
// Self-checking bench for the timer interrupt mask, status and alarm block.
// Assumes the package, constants header and design files are compiled first.
`include "stim_consts.svh"
module stim_top_tb;
  import stim_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Clock, reset and stimulus signals
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [`STIM_ADDR_W-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic period_tick_ev = 1'b0;
  logic dog_overflow_ev = 1'b0;
  logic irq;
  stim_ev_t status_flags;
  stim_rt_t rt_counter_value;
  logic [31:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [31:0] seed = 32'h0318;
  logic [3:0] mask;
  logic [31:0] r;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  always #2 sys_clk = ~sys_clk;
  stim_top DUT (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .period_tick_ev(period_tick_ev),
    .dog_overflow_ev(dog_overflow_ev), .irq(irq), .status_flags(status_flags),
    .rt_counter_value(rt_counter_value));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // The expectation is queued as the strobe goes out; the monitor pairs it with the data.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd
  // Read data stand only in the cycle after the strobe, so they are taken at that edge.
  always @(posedge sys_clk)
  begin
    rd_seen <= reg_rd;
    if (rd_seen)
      check(reg_rdata, exp_q.pop_front());
    cycles++;
    if (cycles == 60000)
    begin
      n_fail++;
      close_out();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(8'h1c, 32'h0);
    rd(8'h20, 32'h0);
    rd(8'h24, 32'h0);
    rd(8'h0c, 32'h8000);
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    wr(8'h30, 32'hffffffff);
    rd(8'h30, 32'h0);
    $display("reset and map test done");
    mask = 4'h0;
    for (int i = 0; i < 8; i++)
    begin
      seed = xorshift(seed);
      r = seed;
      wr(8'h14, r);
      mask = mask | r[3:0];
      rd(8'h1c, {28'h0, mask});
      seed = xorshift(seed);
      r = seed;
      wr(8'h18, r);
      mask = mask & ~r[3:0];
      rd(8'h1c, {28'h0, mask});
    end
    $display("mask command test done");
    @(posedge sys_clk);
    period_tick_ev <= 1'b1;
    dog_overflow_ev <= 1'b1;
    @(posedge sys_clk);
    period_tick_ev <= 1'b0;
    dog_overflow_ev <= 1'b0;
    @(posedge sys_clk);
    check(status_flags, 32'h3);
    check(irq, |(mask & 4'h3));
    wr(8'h18, 32'hf);
    @(posedge sys_clk);
    check(irq, 1'b0);
    wr(8'h14, 32'h2);
    @(posedge sys_clk);
    check(irq, 1'b1);
    rd(8'h10, 32'h3);
    @(posedge sys_clk);
    check(status_flags, 32'h0);
    check(irq, 1'b0);
    $display("event and interrupt test done");
    wr(8'h14, 32'hf);
    seed = xorshift(seed);
    wr(8'h20, {seed[31:20], 20'h00002});
    wr(8'h0c, 32'h1);
    rd(8'h0c, 32'h1);
    rd(8'h20, 32'h2);
    for (int i = 0; i < 20000 && status_flags[3] !== 1'b1; i++)
      @(posedge sys_clk);
    check(rt_counter_value, 32'h2);
    check(status_flags, 32'hc);
    check(irq, 1'b1);
    rd(8'h24, 32'h2);
    rd(8'h10, 32'hc);
    @(posedge sys_clk);
    check(irq, 1'b0);
    $display("alarm and counter test done");
    repeat (3) @(posedge sys_clk);
    close_out();
  end
endmodule : stim_top_tb
